// File: cssb_defines.svh
`ifndef CSSB_DEFINES_SVH
`define CSSB_DEFINES_SVH
// register byte offsets, one aligned word each
`define CSSB_OFF_MEMORY_KIND 12'h000
`define CSSB_OFF_PRESENT_SCAN 12'h004
`define CSSB_OFF_MIN_SCAN 12'h008
`define CSSB_OFF_MAX_SCAN 12'h00c
`define CSSB_OFF_CLK_BASE 12'h010
`define CSSB_OFF_FILTER 12'h030
`define CSSB_OFF_IDX_PRIMARY 12'h034
`define CSSB_OFF_IDX_COMPANION 12'h038
`define CSSB_OFF_CONST_SCAN 12'h03c
`define CSSB_OFF_STATE_BASE 12'h040
`define CSSB_OFF_ALARM_LOW 12'h060
`define CSSB_OFF_CONTROL 12'h064
// memory kind codes
`define CSSB_MEM_CASSETTE_OPEN 16'h0002
`define CSSB_MEM_CASSETTE_PROT 16'h000a
`define CSSB_MEM_BUILTIN 16'h0010
// reset values
`define CSSB_FILTER_RESET 16'h000a
`define CSSB_CONST_SCAN_RESET 16'h0000
`define CSSB_MIN_SCAN_RESET 16'hffff
// timing
`define CSSB_CLK_MHZ 100
`define CSSB_TICK_US 100
`define CSSB_MS_US 1000
`define CSSB_TENTH_MS_CYCLES (`CSSB_CLK_MHZ * `CSSB_TICK_US)
// clock field limits
`define CSSB_SEC_MAX 16'd59
`define CSSB_MIN_MAX 16'd59
`define CSSB_HOUR_MAX 16'd23
`define CSSB_DAY_MIN 16'd1
`define CSSB_DAY_MAX 16'd31
`define CSSB_MON_MIN 16'd1
`define CSSB_MON_MAX 16'd12
`define CSSB_YEAR_MAX 16'd99
`define CSSB_WDAY_MAX 16'd6
// sequencing ranges
`define CSSB_SEQ_LOW_LAST 899
`define CSSB_SEQ_HIGH_FIRST 1000
`define CSSB_SEQ_HIGH_LAST 4095
`define CSSB_ALARM_FIRST 900
`define CSSB_ALARM_LAST 999
`define CSSB_STATE_COUNT 4096
`define CSSB_LIST_LEN 8
`endif

// File: cssb_pkg.sv
`default_nettype none
package cssb_pkg;
  typedef logic [15:0] cssb_word_t;
  typedef enum logic [1:0] {
    CSSB_SCAN_IDLE,
    CSSB_SCAN_RUN,
    CSSB_SCAN_PAD
  } cssb_scan_state_t;
  typedef enum logic [1:0] {
    CSSB_LIST_IDLE,
    CSSB_LIST_WALK
  } cssb_list_state_t;
endpackage
`default_nettype wire

// File: cssb_status_bank.sv
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "cssb_defines.svh"
// status register bank behind an ahb-lite slave port
// tick_cycles is clock cycles per 0.1 ms step, ms_ticks is steps per 1 ms
module cssb_status_bank #(
  parameter int TICK_CYCLES = `CSSB_TENTH_MS_CYCLES,
  parameter int MS_TICKS = `CSSB_MS_US / `CSSB_TICK_US
) (
  input wire logic clock,
  input wire logic rst_n,
  // ahb-lite slave port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // memory straps, asynchronous pins
  input wire logic mem_cassette_present,
  input wire logic mem_protect_switch,
  // scan sequencing from the program executor, same clock
  input wire logic scan_start,
  input wire logic scan_end,
  input wire logic [15:0] const_scan_boot_value,
  // controller state, same clock
  input wire logic [15:0] primary_index_reg,
  input wire logic [15:0] companion_index_reg,
  input wire logic [`CSSB_STATE_COUNT-1:0] sequence_state_active,
  // outputs to the input filter and the scan sequencer
  output logic [15:0] filter_time_out,
  output logic scan_release
);
  import cssb_pkg::*;

  // pin input synchronisers for the switch straps
  // three flops per pin; the filtered level only moves once the second and
  // third stages agree, so a switch that bounces across an edge cannot
  // flip the memory kind code for a single cycle
  // only the second stage reads the first, keeping the metastable node private
  logic [2:0] cass_sync_reg;
  logic [2:0] prot_sync_reg;
  logic cass_reg;
  logic prot_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cass_sync_reg <= 3'h0;
      prot_sync_reg <= 3'h0;
      cass_reg <= 1'b0;
      prot_reg <= 1'b0;
    end else begin
      cass_sync_reg <= {cass_sync_reg[1:0], mem_cassette_present};
      prot_sync_reg <= {prot_sync_reg[1:0], mem_protect_switch};
      if (cass_sync_reg[2] == cass_sync_reg[1]) cass_reg <= cass_sync_reg[2];
      if (prot_sync_reg[2] == prot_sync_reg[1]) prot_reg <= prot_sync_reg[2];
    end
  end

  // memory kind code
  // built-in memory wins whenever no cassette is fitted; the protect switch
  // only matters with a cassette in place
  cssb_word_t memory_kind_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      memory_kind_reg <= `CSSB_MEM_BUILTIN;
    end else if (!cass_reg) begin
      memory_kind_reg <= `CSSB_MEM_BUILTIN;
    end else begin
      memory_kind_reg <= prot_reg ? `CSSB_MEM_CASSETTE_PROT : `CSSB_MEM_CASSETTE_OPEN;
    end
  end

  // ahb address phase capture
  // a write is only known in its address phase but its data comes one cycle
  // later, so the decoded offset and the write flag are held for the data phase
  // reads are answered straight from the address phase, see the output stage
  // only the low twelve address bits are decoded; hsize is not checked, every
  // register being one aligned word
  logic wr_pend_reg;
  logic [11:0] addr_reg;
  logic rd_hit;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
    end else if (hready) begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      if (hsel && htrans[1]) addr_reg <= haddr[11:0];
    end
  end
  // a read is answered when its address phase is taken
  assign rd_hit = hsel && htrans[1] && !hwrite && hready;

  // control: bit0 constant scan, bit1 state list enable, bit2 alarm monitor
  // the three mode flags share one software register so that a single write
  // can switch state listing and alarm monitoring on together
  logic const_scan_flag;
  logic state_list_enable_flag;
  logic alarm_monitor_flag;
  logic [2:0] control_reg;
  // flag names used by the logic below
  assign const_scan_flag = control_reg[0];
  assign state_list_enable_flag = control_reg[1];
  assign alarm_monitor_flag = control_reg[2];

  // writable configuration registers
  // the constant scan duration takes the boot value on the first edge after
  // reset; a write landing on that same edge still wins because it comes later
  // in this process
  // read-only offsets simply have no entry here, so writes to them are dropped
  cssb_word_t filter_reg;
  cssb_word_t const_scan_reg;
  logic boot_load_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      control_reg <= 3'h0;
      filter_reg <= `CSSB_FILTER_RESET;
      const_scan_reg <= `CSSB_CONST_SCAN_RESET;
      boot_load_reg <= 1'b1;
    end else begin
      boot_load_reg <= 1'b0;
      if (boot_load_reg) const_scan_reg <= const_scan_boot_value;
      if (wr_pend_reg) begin
        unique case (addr_reg)
          `CSSB_OFF_CONTROL: control_reg <= hwdata[2:0];
          `CSSB_OFF_FILTER: filter_reg <= hwdata[15:0];
          `CSSB_OFF_CONST_SCAN: const_scan_reg <= hwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // real-time clock fields: index 0 sec .. 6 weekday, out-of-range writes clamp
  // clamping rather than ignoring keeps every field inside its legal range,
  // so software never reads a day of zero or a thirteenth month
  // the fields hold what software wrote; no timekeeping advances them here
  cssb_word_t clk_field_reg [7];
  cssb_word_t clk_lo [7];
  cssb_word_t clk_hi [7];
  assign clk_lo = '{16'd0, 16'd0, 16'd0, `CSSB_DAY_MIN, `CSSB_MON_MIN, 16'd0, 16'd0};
  assign clk_hi = '{`CSSB_SEC_MAX, `CSSB_MIN_MAX, `CSSB_HOUR_MAX, `CSSB_DAY_MAX,
                    `CSSB_MON_MAX, `CSSB_YEAR_MAX, `CSSB_WDAY_MAX};
  generate
    for (genvar gi = 0; gi < 7; gi++) begin : g_clk
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          // reset gives day 1 and month 1, the lowest legal values
          clk_field_reg[gi] <= (gi == 3 || gi == 4) ? 16'd1 : 16'd0;
        end else if (wr_pend_reg && addr_reg == `CSSB_OFF_CLK_BASE + 12'(4 * gi)) begin
          if (hwdata[15:0] < clk_lo[gi]) clk_field_reg[gi] <= clk_lo[gi];
          else if (hwdata[15:0] > clk_hi[gi]) clk_field_reg[gi] <= clk_hi[gi];
          else clk_field_reg[gi] <= hwdata[15:0];
        end
      end
    end
  endgenerate

  // 0.1 ms tick divider, restarted at each scan start
  // restarting the divider aligns the tenth-millisecond grid with the first
  // step of the scan, so a scan shorter than one step reads as zero
  logic [$clog2(TICK_CYCLES+1)-1:0] div_reg;
  logic tick;
  assign tick = (div_reg == ($bits(div_reg))'(TICK_CYCLES - 1));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) div_reg <= '0;
    else if (scan_start || tick) div_reg <= '0;
    else div_reg <= div_reg + 1'b1;
  end

  // scan timer: run until scan_end, then pad if constant scan is on
  // finish marks the edge at which the scan, padding included, is over; the
  // bounds take the count of that edge and scan_release follows one cycle on
  // partial steps are dropped, so times are rounded down to whole 0.1 ms steps
  // the running count saturates instead of wrapping on a very long scan
  cssb_scan_state_t scan_state_reg;
  cssb_word_t present_reg;
  cssb_word_t min_reg;
  cssb_word_t max_reg;
  cssb_word_t target_ticks;
  logic finish;
  // padding target in tenth-millisecond steps, the duration being in 1 ms units
  assign target_ticks = 16'(const_scan_reg * MS_TICKS);
  // a scan without padding ends on scan_end itself; a padded one ends once the
  // count reaches the target
  assign finish = (scan_state_reg == CSSB_SCAN_RUN && scan_end &&
                   !(const_scan_flag && present_reg < target_ticks)) ||
                  (scan_state_reg == CSSB_SCAN_PAD && present_reg >= target_ticks);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scan_state_reg <= CSSB_SCAN_IDLE;
      present_reg <= 16'h0000;
      scan_release <= 1'b0;
    end else begin
      scan_release <= finish;
      unique case (scan_state_reg)
        CSSB_SCAN_IDLE: begin
          // a new scan clears the count
          if (scan_start) begin
            present_reg <= 16'h0000;
            scan_state_reg <= CSSB_SCAN_RUN;
          end
        end
        CSSB_SCAN_RUN: begin
          // scan_end with padding still owed moves on to the pad state
          if (tick && present_reg != 16'hffff) present_reg <= present_reg + 16'h0001;
          if (finish) scan_state_reg <= CSSB_SCAN_IDLE;
          else if (scan_end) scan_state_reg <= CSSB_SCAN_PAD;
        end
        CSSB_SCAN_PAD: begin
          // the count keeps running through the idle padding
          if (finish) scan_state_reg <= CSSB_SCAN_IDLE;
          else if (tick) present_reg <= present_reg + 16'h0001;
        end
      endcase
    end
  end

  // minimum and maximum bounds at scan end
  // the minimum starts at the top of the range so the first finished scan
  // always replaces it; the maximum starts at zero for the same reason
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      min_reg <= `CSSB_MIN_SCAN_RESET;
      max_reg <= 16'h0000;
    end else if (finish) begin
      if (present_reg < min_reg) min_reg <= present_reg;
      if (present_reg > max_reg) max_reg <= present_reg;
    end
  end

  // index mirrors, same-clock logic
  // the index registers live on this clock, so one register stage is enough
  // and the mirrors trail them by a single cycle
  cssb_word_t idx_p_reg;
  cssb_word_t idx_c_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idx_p_reg <= 16'h0000;
      idx_c_reg <= 16'h0000;
    end else begin
      idx_p_reg <= primary_index_reg;
      idx_c_reg <= companion_index_reg;
    end
  end

  // state list walker: one state per cycle, ascending
  // walking upward from state zero gives the ascending order for free; the
  // first eight hits fill the list and the rest are counted no further
  // results are built in working copies and published only at the end of a
  // pass, so software never sees a half-filled list
  // a full pass takes one cycle per state plus one to restart
  cssb_list_state_t list_state_reg;
  logic [11:0] walk_reg;
  logic [3:0] fill_reg;
  cssb_word_t work_list_reg [`CSSB_LIST_LEN];
  cssb_word_t list_reg [`CSSB_LIST_LEN];
  cssb_word_t work_alarm_reg;
  cssb_word_t alarm_reg;
  logic in_seq;
  logic in_alarm;
  // the alarm range sits between the two sequencing ranges and is kept out
  // of the list, it has its own register
  assign in_seq = sequence_state_active[walk_reg] &&
                  (walk_reg <= 12'(`CSSB_SEQ_LOW_LAST) || walk_reg >= 12'(`CSSB_SEQ_HIGH_FIRST));
  assign in_alarm = sequence_state_active[walk_reg] &&
                    walk_reg >= 12'(`CSSB_ALARM_FIRST) && walk_reg <= 12'(`CSSB_ALARM_LAST);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      list_state_reg <= CSSB_LIST_IDLE;
      walk_reg <= 12'h000;
      fill_reg <= 4'h0;
      work_alarm_reg <= 16'h0000;
      alarm_reg <= 16'h0000;
      for (int i = 0; i < `CSSB_LIST_LEN; i++) begin
        work_list_reg[i] <= 16'h0000;
        list_reg[i] <= 16'h0000;
      end
    end else begin
      unique case (list_state_reg)
        CSSB_LIST_IDLE: begin
          // start a fresh pass whenever either flag asks for results
          if (state_list_enable_flag || alarm_monitor_flag) begin
            walk_reg <= 12'h000;
            fill_reg <= 4'h0;
            work_alarm_reg <= 16'h0000;
            for (int i = 0; i < `CSSB_LIST_LEN; i++) work_list_reg[i] <= 16'h0000;
            list_state_reg <= CSSB_LIST_WALK;
          end
        end
        CSSB_LIST_WALK: begin
          if (in_seq && fill_reg < 4'(`CSSB_LIST_LEN)) begin
            work_list_reg[fill_reg[2:0]] <= {4'h0, walk_reg};
            fill_reg <= fill_reg + 4'h1;
          end
          if (in_alarm && work_alarm_reg == 16'h0000) work_alarm_reg <= {4'h0, walk_reg};
          if (walk_reg == 12'(`CSSB_SEQ_HIGH_LAST)) begin
            // the last state is still being checked on this edge, so its hit is
            // merged straight into the published copy
            if (state_list_enable_flag) begin
              for (int i = 0; i < `CSSB_LIST_LEN; i++) list_reg[i] <= work_list_reg[i];
              if (in_seq && fill_reg < 4'(`CSSB_LIST_LEN)) list_reg[fill_reg[2:0]] <= {4'h0, walk_reg};
            end
            if (alarm_monitor_flag) alarm_reg <= work_alarm_reg;
            list_state_reg <= CSSB_LIST_IDLE;
          end else begin
            walk_reg <= walk_reg + 12'h001;
          end
        end
      endcase
    end
  end

  // read mux
  // decoded from the live address phase so the word can be registered at the
  // end of that phase and stand through the data phase
  // unmapped offsets read as zero
  cssb_word_t rd_word;
  always_comb begin
    rd_word = 16'h0000;
    unique case (haddr[11:0])
      `CSSB_OFF_MEMORY_KIND: rd_word = memory_kind_reg;
      `CSSB_OFF_PRESENT_SCAN: rd_word = present_reg;
      `CSSB_OFF_MIN_SCAN: rd_word = min_reg;
      `CSSB_OFF_MAX_SCAN: rd_word = max_reg;
      `CSSB_OFF_FILTER: rd_word = filter_reg;
      `CSSB_OFF_IDX_PRIMARY: rd_word = idx_p_reg;
      `CSSB_OFF_IDX_COMPANION: rd_word = idx_c_reg;
      `CSSB_OFF_CONST_SCAN: rd_word = const_scan_reg;
      `CSSB_OFF_ALARM_LOW: rd_word = alarm_reg;
      `CSSB_OFF_CONTROL: rd_word = {13'h0, control_reg};
      default: begin
        for (int i = 0; i < 7; i++)
          if (haddr[11:0] == `CSSB_OFF_CLK_BASE + 12'(4 * i)) rd_word = clk_field_reg[i];
        for (int i = 0; i < `CSSB_LIST_LEN; i++)
          if (haddr[11:0] == `CSSB_OFF_STATE_BASE + 12'(4 * i)) rd_word = list_reg[i];
      end
    endcase
  end

  // registered bus outputs, zero wait states, always okay
  // every output leaves a flop; hrdata keeps the last read word until the
  // next read so a slow master can still pick it up
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      filter_time_out <= `CSSB_FILTER_RESET;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      filter_time_out <= filter_reg;
      if (rd_hit) hrdata <= {16'h0000, rd_word};
    end
  end
endmodule
`default_nettype wire

// File: cssb_status_bank_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "cssb_defines.svh"
module cssb_status_bank_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic scan_end,
  input wire logic [15:0] filter_time_out,
  input wire logic scan_release
);
  logic take;
  logic ended_reg;
  logic filt_wr_reg;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // transfer accepted on this edge
  assign take = hsel && hready && htrans[1];
  // scan end seen and not yet released
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ended_reg <= 1'b0;
    end else if (scan_end) begin
      ended_reg <= 1'b1;
    end else if (scan_release) begin
      ended_reg <= 1'b0;
    end
  end
  // filter register write in address phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      filt_wr_reg <= 1'b0;
    end else begin
      filt_wr_reg <= take && hwrite && (haddr[11:0] == `CSSB_OFF_FILTER);
    end
  end
  chk_ready_high: assert property (hreadyout == 1'b1) else $error("hreadyout low");
  chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  chk_release_pulse: assert property (scan_release |=> !scan_release) else $error("release too long");
  chk_release_cause: assert property (scan_release |-> ended_reg) else $error("release without end");
  chk_rdata_upper: assert property (hrdata[31:16] == 16'h0000) else $error("upper read bits set");
  chk_rdata_hold: assert property (!$past(take && !hwrite) |-> $stable(hrdata)) else $error("read data moved");
  chk_filter_cause: assert property ($changed(filter_time_out) |->
    ($past(filt_wr_reg) || $past(filt_wr_reg, 2))) else $error("filter changed unasked");
  chk_filter_reset: assert property ($rose(rst_n) |-> filter_time_out == `CSSB_FILTER_RESET)
    else $error("filter reset");
endmodule
bind cssb_status_bank cssb_status_bank_chk cssb_status_bank_chk_inst (.clock(clock), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .scan_end(scan_end), .filter_time_out(filter_time_out), .scan_release(scan_release));
`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock, rst_n, hsel, hwrite, scan_start, scan_end, cas, prot, hreadyout, hresp, scan_release;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] boot, pidx, cidx, filter_time_out;
  logic [4095:0] act;
  int miscompares, checks;
  int lst [10] = '{3, 5, 7, 11, 13, 1000, 1001, 2000, 3000, 4095};
  cssb_status_bank #(.TICK_CYCLES(20), .MS_TICKS(10)) cssb_status_bank_inst (.clock(clock), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_cassette_present(cas),
    .mem_protect_switch(prot), .scan_start(scan_start), .scan_end(scan_end), .const_scan_boot_value(boot),
    .primary_index_reg(pidx), .companion_index_reg(cidx), .sequence_state_active(act),
    .filter_time_out(filter_time_out), .scan_release(scan_release));
  // verdict and end of run, reached from the tests and the watchdog
  task wrap_up;
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one compare for every result, counted and reported
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single transfer, address phase then data phase
  task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {20'h0, a};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  // read one register and compare it
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // one scan of cyc cycles, then the three scan time registers
  task scan(input int cyc, input logic [15:0] ep, input logic [15:0] mn, input logic [15:0] mx);
    int n;
    n = 0;
    scan_start <= 1'b1; @(posedge clock); scan_start <= 1'b0;
    repeat (cyc) @(posedge clock);
    scan_end <= 1'b1; @(posedge clock); scan_end <= 1'b0;
    while (scan_release !== 1'b1 && n < 2000) begin @(posedge clock); n++; end
    cmp({31'h0, scan_release}, 32'h1);
    @(posedge clock);
    rdc(12'h004, {16'h0, ep});
    rdc(12'h008, {16'h0, mn});
    rdc(12'h00c, {16'h0, mx});
  endtask
  // values straight after reset and the power-on load
  task t_reset;
    rdc(12'h000, 32'h10);
    rdc(12'h030, 32'ha);
    cmp({16'h0, filter_time_out}, 32'ha);
    rdc(12'h03c, 32'h7);
  endtask
  // memory kind from the straps, a read-only write and an unmapped read
  task t_mem;
    cas <= 1'b1; repeat (10) @(posedge clock);
    rdc(12'h000, 32'h2);
    prot <= 1'b1; repeat (10) @(posedge clock);
    rdc(12'h000, 32'ha);
    wr(12'h000, 32'h55);
    rdc(12'h000, 32'ha);
    rdc(12'h100, 32'h0);
    cas <= 1'b0;
    repeat (10) @(posedge clock);
    rdc(12'h000, 32'h10);
  endtask
  // clock fields with clamping, filter time and index mirrors
  task t_regs;
    wr(12'h010, 32'd45); rdc(12'h010, 32'd45);
    wr(12'h010, 32'd60); rdc(12'h010, 32'd59);
    wr(12'h018, 32'd24); rdc(12'h018, 32'd23);
    rdc(12'h014, 32'd0);
    wr(12'h01c, 32'd20);
    wr(12'h01c, 32'd0);
    rdc(12'h01c, 32'd1);
    wr(12'h020, 32'd13);
    rdc(12'h020, 32'd12);
    wr(12'h024, 32'd100);
    rdc(12'h024, 32'd99);
    wr(12'h028, 32'd7);
    rdc(12'h028, 32'd6);
    wr(12'h028, 32'd6); rdc(12'h028, 32'd6);
    wr(12'h030, 32'h3); rdc(12'h030, 32'h3);
    cmp({16'h0, filter_time_out}, 32'h3);
    pidx <= 16'h1234; cidx <= 16'hbeef; repeat (2) @(posedge clock);
    rdc(12'h034, 32'h1234);
    rdc(12'h038, 32'hbeef);
  endtask
  // scans of 5 then 3 ticks, then a 1 tick scan padded to 1 ms
  task t_scan;
    scan(110, 16'd5, 16'd5, 16'd5);
    scan(70, 16'd3, 16'd3, 16'd5);
    wr(12'h03c, 32'h1); rdc(12'h03c, 32'h1);
    wr(12'h064, 32'h1);
    scan(30, 16'd10, 16'd3, 16'd10);
    wr(12'h064, 32'h0);
  endtask
  // ten active states, two alarm states
  task t_list;
    for (int i = 0; i < 10; i++) act[lst[i]] <= 1'b1;
    act[950] <= 1'b1; act[920] <= 1'b1;
    wr(12'h064, 32'h6);
    repeat (4300) @(posedge clock);
    for (int i = 0; i < 8; i++) rdc(12'h040 + 12'(4 * i), 32'(lst[i]));
    rdc(12'h060, 32'd920);
  endtask
  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // reset for 20 cycles, then the scenarios in order
  initial begin
    rst_n <= 1'b0; hsel <= 1'b0; hwrite <= 1'b0; haddr <= '0; hwdata <= '0; htrans <= 2'b00;
    hsize <= 3'b010; scan_start <= 1'b0; scan_end <= 1'b0; cas <= 1'b0; prot <= 1'b0;
    boot <= 16'h0007; pidx <= '0; cidx <= '0; act <= '0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset; t_mem; t_regs; t_scan; t_list;
    wrap_up;
  end
  // watchdog, well beyond the length of all scenarios
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    wrap_up;
  end
endmodule
`default_nettype wire
